// [design/psr_pkg.sv]
package psr_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int INIT_TIME_US = 50;
  localparam int INIT_CYC = (INIT_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
  localparam int MAX_SEL_US = 15;
  localparam int MAX_SEL_CYC = MAX_SEL_US * 1000 / CLK_PERIOD_NS;
  localparam int GAP_NS = 5;
  // strictly more than the gap, at least one cycle
  localparam int GAP_CYC = GAP_NS / CLK_PERIOD_NS + 1;
  localparam int ACC_NS = 70;
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_NS = 30;
  localparam int SETUP_NS = 30;
  // strobe longer than float plus setup, kept no shorter than access time too
  localparam int WP_SUM_CYC = (FLOAT_NS + SETUP_NS) / CLK_PERIOD_NS + 1;
  localparam int WP_CYC = (WP_SUM_CYC > ACC_CYC) ? WP_SUM_CYC : ACC_CYC;
  localparam int HOLD_CYC = 1;
  localparam int CNT_W = 16;

  typedef enum logic [4:0] {
    PSR_INIT = 5'h01,
    PSR_IDLE = 5'h02,
    PSR_READ = 5'h04,
    PSR_WRITE = 5'h08,
    PSR_HOLD = 5'h10
  } psr_state_type;

  typedef struct packed {
    psr_state_type st;
    logic [CNT_W-1:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [1:0] lane_n;
    logic sel;
    logic we_n;
    logic oe_n;
    logic dq_oe;
    logic rvalid;
    logic done;
  } psr_regs_type;
endpackage

// [design/psr_host.sv]
`timescale 1ns/100ps
module psr_host
  import psr_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CYC,
  parameter int MAX_SEL_CYCLES = MAX_SEL_CYC
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] req_lane_en_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_rdata_o,
  output logic wr_done_o,
  output logic init_busy_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic primary_select_n_o,
  output logic secondary_select_o,
  output logic output_drive_n_o,
  output logic write_strobe_n_o,
  output logic upper_lane_n_o,
  output logic lower_lane_n_o,
  input wire logic [DATA_W-1:0] mem_dq_i,
  output logic [DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_o
);

  psr_regs_type r_q, r_d;
  logic [CNT_W-1:0] sel_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    r_d.done = 1'b0;
    case (r_q.st)
      PSR_INIT: begin
        // select held off during self-initialisation
        if (r_q.cnt == CNT_W'(INIT_CYCLES - 1)) begin
          r_d.st = PSR_IDLE;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      PSR_IDLE: begin
        // all qualifiers set up together with address and data
        if (req_valid_i && req_lane_en_i != 2'b00) begin
          r_d.addr = req_addr_i;
          r_d.wdata = req_wdata_i;
          r_d.lane_n = ~req_lane_en_i;
          r_d.sel = 1'b1;
          r_d.cnt = '0;
          if (req_write_i) begin
            r_d.st = PSR_WRITE;
            r_d.we_n = 1'b0;
            r_d.oe_n = 1'b1;
            r_d.dq_oe = 1'b1;
          end else begin
            r_d.st = PSR_READ;
            r_d.we_n = 1'b1;
            r_d.oe_n = 1'b0;
            r_d.dq_oe = 1'b0;
          end
        end
      end
      PSR_READ: begin
        if (r_q.cnt == CNT_W'(ACC_CYC - 1)) begin
          r_d.rdata = mem_dq_i;
          r_d.rvalid = 1'b1;
          r_d.st = PSR_HOLD;
          r_d.cnt = '0;
          r_d.sel = 1'b0;
          r_d.oe_n = 1'b1;
          r_d.lane_n = 2'b11;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      PSR_WRITE: begin
        // strobe released alone ends the write; data held one more cycle
        if (r_q.cnt == CNT_W'(WP_CYC - 1)) begin
          r_d.we_n = 1'b1;
          r_d.st = PSR_HOLD;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      PSR_HOLD: begin
        // close select and data after the write end, then idle the gap
        r_d.sel = 1'b0;
        r_d.dq_oe = 1'b0;
        r_d.lane_n = 2'b11;
        if (r_q.sel) begin
          r_d.done = ~r_q.dq_oe ? 1'b0 : 1'b1;
          r_d.cnt = '0;
        end else if (r_q.cnt == CNT_W'(GAP_CYC - 1)) begin
          r_d.st = PSR_IDLE;
          r_d.cnt = '0;
        end else begin
          r_d.cnt = r_q.cnt + 1'b1;
        end
      end
      default: begin
        r_d.st = PSR_INIT;
        r_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_q <= '{st: PSR_INIT, cnt: '0, addr: '0, wdata: '0, rdata: '0,
               lane_n: 2'b11, sel: 1'b0, we_n: 1'b1, oe_n: 1'b1,
               dq_oe: 1'b0, rvalid: 1'b0, done: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // select-window watch, helper for the window check
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_cnt_q <= '0;
    end else if (r_q.sel) begin
      sel_cnt_q <= sel_cnt_q + 1'b1;
    end else begin
      sel_cnt_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign req_ready_o = (r_q.st == PSR_IDLE);
  assign rsp_valid_o = r_q.rvalid;
  assign rsp_rdata_o = r_q.rdata;
  assign wr_done_o = r_q.done;
  assign init_busy_o = (r_q.st == PSR_INIT);
  assign mem_addr_o = r_q.addr;
  assign primary_select_n_o = ~r_q.sel;
  assign secondary_select_o = r_q.sel;
  assign output_drive_n_o = r_q.oe_n;
  assign write_strobe_n_o = r_q.we_n;
  assign upper_lane_n_o = r_q.lane_n[1];
  assign lower_lane_n_o = r_q.lane_n[0];
  assign mem_dq_o = r_q.wdata;
  assign mem_dq_oe_o = r_q.dq_oe;

  ////////////////////////////////////////////////////////////////////////////
  property p_init_desel;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      init_busy_o |-> primary_select_n_o && !secondary_select_o;
  endproperty
  a_init_desel: assert property (p_init_desel)
    else $error("select during init");

  property p_sel_window;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      sel_cnt_q < CNT_W'(MAX_SEL_CYCLES);
  endproperty
  a_sel_window: assert property (p_sel_window)
    else $error("select window too long");

  property p_gap;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(primary_select_n_o) |-> primary_select_n_o [*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("deselect gap too short");

  property p_addr_stable;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !primary_select_n_o && $past(!primary_select_n_o)
        |-> $stable(mem_addr_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved while selected");

  property p_wpulse;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(write_strobe_n_o) |-> !write_strobe_n_o [*7];
  endproperty
  a_wpulse: assert property (p_wpulse)
    else $error("write pulse too short");

  property p_data_hold;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $rose(write_strobe_n_o) |-> mem_dq_oe_o && $stable(mem_dq_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("write data not held at write end");

  property p_we_in_sel;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      !write_strobe_n_o |-> !primary_select_n_o && secondary_select_o;
  endproperty
  a_we_in_sel: assert property (p_we_in_sel)
    else $error("strobe outside select");

  property p_no_clash;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      mem_dq_oe_o |-> output_drive_n_o;
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("bus contention");

  property p_read_time;
    @(posedge clk_sys_i) disable iff (!nrst_i)
      $fell(output_drive_n_o) |-> ##7 rsp_valid_o;
  endproperty
  a_read_time: assert property (p_read_time)
    else $error("read answer late");

  c_read: cover property (@(posedge clk_sys_i) rsp_valid_o);
  c_write: cover property (@(posedge clk_sys_i) wr_done_o);
  c_b2b: cover property (@(posedge clk_sys_i)
    wr_done_o ##[1:10] rsp_valid_o);
endmodule

// [testbench/psr_mem_model.sv]
`timescale 1ns/100ps
module psr_mem_model
  import psr_pkg::*;
#(
  parameter int DLY_NS = 60,
  parameter int INIT_NS = 50000,
  parameter int WIN_NS = 15000,
  parameter int DESEL_NS = 5
) (
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic primary_select_n_i,
  input wire logic secondary_select_i,
  input wire logic output_drive_n_i,
  input wire logic write_strobe_n_i,
  input wire logic upper_lane_n_i,
  input wire logic lower_lane_n_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic dq_oe_i,
  output logic [DATA_W-1:0] dq_o,
  output logic fault_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] wd, q, rd;
  logic [ADDR_W-1:0] a_on;
  logic [1:0] wl = 2'h0;
  logic sel, wr, rdo;
  realtime t_on = 0, t_off = 0;
  initial fault_o = 1'b0;
  assign sel = !primary_select_n_i && secondary_select_i;
  assign wr = sel && !write_strobe_n_i
    && !(upper_lane_n_i && lower_lane_n_i);
  assign rdo = sel && write_strobe_n_i && !output_drive_n_i;
  //////////////////////////////////////////////////////////////////////////
  always @* if (wr) begin
    wd = dq_i;
    wl = ~{upper_lane_n_i, lower_lane_n_i};
  end
  always @(negedge wr) if (wl != 2'h0) begin
    if (addr_i !== a_on) fault_o = 1'b1;
    rd = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
    if (wl[1]) rd[15:8] = wd[15:8];
    if (wl[0]) rd[7:0] = wd[7:0];
    mem[addr_i] = rd;
    wl = 2'h0;
  end
  // sample after the select edge has settled, address and select race
  always @(posedge sel) #1 a_on = addr_i;
  // refresh only while deselected; an overlong select loses contents
  always @(sel) begin
    if (sel) begin
      if ($realtime - t_off <= DESEL_NS || $realtime < INIT_NS)
        fault_o = 1'b1;
      t_on = $realtime;
    end else if (sel === 1'b0) begin
      if ($realtime - t_on > WIN_NS) begin
        fault_o = 1'b1;
        mem.delete();
      end
      t_off = $realtime;
    end
  end
  // unselected lanes show inverted data, never a stale copy
  always @(addr_i, rdo, upper_lane_n_i, lower_lane_n_i, wr) begin
    q = mem.exists(addr_i) ? mem[addr_i] : 16'h0000;
    dq_o <= #DLY_NS {rdo && !upper_lane_n_i ? q[15:8] : ~q[15:8],
                     rdo && !lower_lane_n_i ? q[7:0] : ~q[7:0]};
  end
  always @(dq_oe_i, rdo) if (dq_oe_i && rdo) fault_o = 1'b1;
endmodule

// [testbench/psr_host_tb.sv]
`timescale 1ns/100ps
module psr_host_tb
  import psr_pkg::*;
;
  logic clk_sys_i = 0, nrst_i = 0, req_valid_i = 0, req_write_i = 0;
  logic [ADDR_W-1:0] req_addr_i = '0, maddr;
  logic [DATA_W-1:0] req_wdata_i = '0, rdata, dq_in, dq_out;
  logic [1:0] req_lane_en_i = '0;
  logic req_ready_o, rsp_valid_o, wr_done_o, init_busy_o, fault;
  logic pri_n, sec, oe_n, we_n, ub_n, lb_n, dq_oe;
  int fails = 0, checked = 0, i, n;
  logic [54:0] rows [9] = '{
    {1'b1, 2'h3, 20'h00000, 16'ha5c3, 16'h0000},
    {1'b1, 2'h3, 20'hfffff, 16'h1234, 16'h0000},
    {1'b0, 2'h3, 20'h00000, 16'h0000, 16'ha5c3},
    {1'b0, 2'h3, 20'hfffff, 16'h0000, 16'h1234},
    {1'b1, 2'h1, 20'h00000, 16'hff00, 16'h0000},
    {1'b1, 2'h2, 20'hfffff, 16'h5600, 16'h0000},
    {1'b0, 2'h3, 20'h00000, 16'h0000, 16'ha500},
    {1'b0, 2'h3, 20'hfffff, 16'h0000, 16'h5634},
    {1'b0, 2'h2, 20'hfffff, 16'h0000, 16'h5634}};
  always #5 clk_sys_i = ~clk_sys_i;
  psr_host #(.INIT_CYCLES(4), .MAX_SEL_CYCLES(1500)) psr_host_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_lane_en_i(req_lane_en_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rdata), .wr_done_o(wr_done_o), .init_busy_o(init_busy_o),
    .mem_addr_o(maddr), .primary_select_n_o(pri_n),
    .secondary_select_o(sec), .output_drive_n_o(oe_n),
    .write_strobe_n_o(we_n), .upper_lane_n_o(ub_n), .lower_lane_n_o(lb_n),
    .mem_dq_i(dq_in), .mem_dq_o(dq_out), .mem_dq_oe_o(dq_oe));
  psr_mem_model #(.INIT_NS(100)) psr_mem_model_inst (
    .addr_i(maddr), .primary_select_n_i(pri_n), .secondary_select_i(sec),
    .output_drive_n_i(oe_n), .write_strobe_n_i(we_n),
    .upper_lane_n_i(ub_n), .lower_lane_n_i(lb_n), .dq_i(dq_out),
    .dq_oe_i(dq_oe), .dq_o(dq_in), .fault_o(fault));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [19:0] e, logic [19:0] g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(logic [54:0] r);
    logic [15:0] m;
    m = {{8{r[53]}}, {8{r[52]}}};
    req_valid_i <= 1'b1;
    {req_write_i, req_lane_en_i, req_addr_i, req_wdata_i} <= r[54:16];
    n = 0;
    do begin @(posedge clk_sys_i); n++; end
    while (req_ready_o !== 1'b1 && n < 50);
    req_valid_i <= 1'b0;
    do begin @(posedge clk_sys_i); n++; end
    while ((r[54] ? wr_done_o : rsp_valid_o) !== 1'b1 && n < 80);
    if (n >= 80) begin
      fails++;
      end_sim();
    end else if (!r[54]) begin
      chk("rdata", {4'h0, r[15:0] & m}, {4'h0, rdata & m});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    chk("sel_idle", 20'h2, {pri_n, sec});
    chk("init_busy", 20'h1, init_busy_o);
    nrst_i <= 1'b1;
    for (i = 0; i < 9; i++) begin
      xfer(rows[i]);
      $display("row %0d done", i);
    end
    req_valid_i <= 1'b1;
    req_lane_en_i <= 2'h0;
    n = 0;
    repeat (12) begin @(posedge clk_sys_i); n += !pri_n; end
    chk("no_lane_sel", 20'h0, 20'(n));
    req_valid_i <= 1'b0;
    $display("empty lanes done");
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= 1'b0;
    req_lane_en_i <= 2'h3;
    repeat (4) @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
    nrst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("rst_sel", 20'h2, {pri_n, sec});
    chk("rst_busy", 20'h1, init_busy_o);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk("rst_init_sel", 20'h2, {pri_n, sec});
    xfer(rows[6]);
    $display("mid reset done");
    chk("device_fault", 20'h0, fault);
    end_sim();
  end
endmodule
